// ==== logic/gdm_pkg.sv ====
package gdm_pkg;
  // Register byte addresses on the plain register port (one register every four bytes)
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_SENSE = 6'h04;
  localparam logic [5:0] ADDR_OCTHR = 6'h08;
  localparam logic [5:0] ADDR_BOOST = 6'h0c;
  localparam logic [5:0] ADDR_SLEW = 6'h10;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h14;
  localparam logic [5:0] ADDR_IRQ_CLR = 6'h18;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h1c;
  localparam logic [5:0] ADDR_LIVE = 6'h20;
  // Control register fields
  localparam int CTRL_CMP_EN = 0;
  localparam int CTRL_AMP_EN = 2;
  localparam int CTRL_ACT0 = 4;
  localparam int CTRL_ACT1 = 5;
  localparam int CTRL_DCL_EN = 6;
  localparam int CTRL_BOOST_EN = 7;
  // Status / enable layout
  localparam int ST_HS = 0;
  localparam int ST_LS = 3;
  localparam int ST_LV = 6;
  localparam int ST_HV = 7;
  localparam int ST_OC = 8;
  localparam int ST_BITS = 10;
  // Fixed prefix of the threshold converter code
  localparam logic [1:0] OC_DAC_PREFIX = 2'h3;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] SENSE_RST = 3'h0;
  localparam logic [7:0] OCTHR_RST = 8'h00;
  localparam logic [7:0] BOOST_DIV_RST = 8'h01;
  localparam logic [3:0] BOOST_LIM_RST = 4'h0;
  localparam logic [2:0] SLEW_RST = 3'h0;
  // Slew reference current in uA: base plus step per code
  localparam int SLEW_BASE_UA = 10;
  localparam int SLEW_STEP_UA = 10;
endpackage

// ==== logic/gdm_sync.sv ====
`timescale 1ns/100ps
// Two-flop synchroniser, one per bit
module gdm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ==== logic/gdm_core.sv ====
`timescale 1ns/100ps
//
// Contract
// - Three-bit field selects the current sense amplifier input offset.
// - Threshold code is prefix 11 above four-bit field; amplifier compared against it.
// - Overcurrent comparator works only with its enable and amplifier enable set.
// - DC-link pin divided by five reaches the ADC only while monitor enabled.
// - Boost switching clock comes from bus clock through programmable divider.
// - Four-bit field selects the boost coil current limit.
// - Boost clock passes only when enabled and supply feedback below reference.
// - Interrupt requests only in run mode.
// - Stop mode entry or exit leaves all interrupt flags unchanged.
// - Line 0 asserts on any desaturation flag with desaturation enable set.
// - Line 1 asserts on low or high voltage or overcurrent with enables.
// - Slew field sets reference current 10uA plus code times 10uA.
// - Desaturation flag cleared by writing one; pre-driver resumes PWM.
module gdm_core
  import gdm_pkg::*;
#(
  parameter int DIV_WIDTH = 8
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Register port
  input wire logic [5:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // Analog side: comparator and monitor results (asynchronous)
  input wire logic [2:0] HS_DESAT_IN,
  input wire logic [2:0] LS_DESAT_IN,
  input wire logic LOW_VOLTAGE_IN,
  input wire logic HIGH_VOLTAGE_IN,
  input wire logic [1:0] OC_CMP_IN,
  input wire logic SUPPLY_BELOW_REF_IN,
  // Processor mode
  input wire logic STOP_MODE_IN,
  // PWM sources for the pre-drivers
  input wire logic [5:0] PWM_IN,
  // Analog controls
  output logic [2:0] SENSE_OFFSET_SEL_OUT,
  output logic [1:0] SENSE_AMP_EN_OUT,
  output logic [1:0] OC_CMP_EN_OUT,
  output logic [5:0] OC_DAC0_OUT,
  output logic [5:0] OC_DAC1_OUT,
  output logic DC_LINK_MUX_EN_OUT,
  output logic [3:0] BOOST_CURRENT_LIMIT_OUT,
  output logic BOOST_SWITCH_OUT,
  output logic [2:0] HIGH_SIDE_SLEW_SEL_OUT,
  output logic [6:0] SLEW_REF_UA_OUT,
  // Gate drive
  output logic [5:0] GATE_OUT,
  // Interrupts
  output logic IRQ0_OUT,
  output logic IRQ1_OUT
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] sense_offset_sel;
    logic [7:0] overcurrent_threshold;
    logic [DIV_WIDTH-1:0] boost_div;
    logic [3:0] boost_current_limit;
    logic [2:0] high_side_slew_sel;
    logic [ST_BITS-1:0] stat;
    logic [ST_BITS-1:0] irq_en;
    logic [DIV_WIDTH-1:0] div_cnt;
    logic boost_clk;
    logic [31:0] rdata;
  } gdm_state_t;

  gdm_state_t st;
  gdm_state_t next_st;

  logic [2:0] hs_desat;
  logic [2:0] ls_desat;
  logic lv;
  logic hv;
  logic [1:0] oc_raw;
  logic below_ref;
  logic stop_mode;
  logic [1:0] oc_live;
  logic [ST_BITS-1:0] events;
  logic [ST_BITS-1:0] clr;
  logic boost_tick;

  // Pin-level status passes two flops before use
  gdm_sync #(
    .WIDTH(12)
  ) u_sync (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .d_in({HS_DESAT_IN, STOP_MODE_IN, SUPPLY_BELOW_REF_IN, OC_CMP_IN, HIGH_VOLTAGE_IN,
      LOW_VOLTAGE_IN, LS_DESAT_IN}),
    .q_out({hs_desat, stop_mode, below_ref, oc_raw, hv, lv, ls_desat})
  );

  // Comparator results count only with both enables set
  assign oc_live = oc_raw & OC_CMP_EN_OUT & SENSE_AMP_EN_OUT;
  assign events = {oc_live, hv, lv, ls_desat, hs_desat};
  assign clr = (WR_IN && ADDR_IN == ADDR_IRQ_CLR) ? WDATA_IN[ST_BITS-1:0] : '0;
  assign boost_tick = (st.div_cnt == '0);

  // Next-state logic: register writes, sticky flags, divider
  always_comb begin
    next_st = st;
    if (WR_IN) begin
      unique case (ADDR_IN)
        ADDR_CTRL: next_st.ctrl = WDATA_IN[7:0];
        ADDR_SENSE: next_st.sense_offset_sel = WDATA_IN[2:0];
        ADDR_OCTHR: next_st.overcurrent_threshold = WDATA_IN[7:0];
        ADDR_BOOST: begin
          next_st.boost_div = WDATA_IN[DIV_WIDTH-1:0];
          next_st.boost_current_limit = WDATA_IN[DIV_WIDTH+3:DIV_WIDTH];
        end
        ADDR_SLEW: next_st.high_side_slew_sel = WDATA_IN[2:0];
        ADDR_IRQ_EN: next_st.irq_en = WDATA_IN[ST_BITS-1:0];
        default: ;
      endcase
    end
    // Set beats clear; stop mode does not touch the flags
    next_st.stat = (st.stat & ~clr) | events;
    // Divider reloads so the switch toggles once per boost_div+1 cycles
    if (boost_tick) begin
      next_st.div_cnt = st.boost_div;
      next_st.boost_clk = ~st.boost_clk;
    end else begin
      next_st.div_cnt = st.div_cnt - 1'b1;
    end
    // Read data stand for exactly the cycle after the strobe
    next_st.rdata = '0;
    if (RD_IN) begin
      unique case (ADDR_IN)
        ADDR_CTRL: next_st.rdata = {24'h0, st.ctrl};
        ADDR_SENSE: next_st.rdata = {29'h0, st.sense_offset_sel};
        ADDR_OCTHR: next_st.rdata = {24'h0, st.overcurrent_threshold};
        ADDR_BOOST: next_st.rdata = 32'({st.boost_current_limit, st.boost_div});
        ADDR_SLEW: next_st.rdata = {29'h0, st.high_side_slew_sel};
        ADDR_IRQ_STAT: next_st.rdata = 32'(st.stat);
        ADDR_IRQ_EN: next_st.rdata = 32'(st.irq_en);
        ADDR_LIVE: next_st.rdata = 32'({below_ref, events});
        default: next_st.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      st.ctrl <= CTRL_RST;
      st.sense_offset_sel <= SENSE_RST;
      st.overcurrent_threshold <= OCTHR_RST;
      st.boost_div <= DIV_WIDTH'(BOOST_DIV_RST);
      st.boost_current_limit <= BOOST_LIM_RST;
      st.high_side_slew_sel <= SLEW_RST;
      st.stat <= '0;
      st.irq_en <= '0;
      st.div_cnt <= '0;
      st.boost_clk <= 1'b0;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Analog control outputs straight from registers
  assign RDATA_OUT = st.rdata;
  assign SENSE_OFFSET_SEL_OUT = st.sense_offset_sel;
  assign OC_CMP_EN_OUT = st.ctrl[CTRL_CMP_EN+1:CTRL_CMP_EN];
  assign SENSE_AMP_EN_OUT = st.ctrl[CTRL_AMP_EN+1:CTRL_AMP_EN];
  assign OC_DAC0_OUT = {OC_DAC_PREFIX, st.overcurrent_threshold[3:0]};
  assign OC_DAC1_OUT = {OC_DAC_PREFIX, st.overcurrent_threshold[7:4]};
  assign DC_LINK_MUX_EN_OUT = st.ctrl[CTRL_DCL_EN];
  assign BOOST_CURRENT_LIMIT_OUT = st.boost_current_limit;
  assign HIGH_SIDE_SLEW_SEL_OUT = st.high_side_slew_sel;
  // Reference current in uA for the pre-driver current source
  assign SLEW_REF_UA_OUT = 7'(SLEW_BASE_UA + SLEW_STEP_UA * st.high_side_slew_sel);

  // Gated switching clock; feedback above reference parks the switch low
  assign BOOST_SWITCH_OUT = st.boost_clk & st.ctrl[CTRL_BOOST_EN] & below_ref;

  // Fault shutdown of pre-drivers; desat clears per phase, overcurrent by action bit.
  // Mixed action bits are not defended against; software keeps them equal.
  logic oc_all_off;
  logic oc_hs_off;
  assign oc_all_off = (st.stat[ST_OC] & st.ctrl[CTRL_ACT0]) | (st.stat[ST_OC+1] & st.ctrl[CTRL_ACT1]) |
    st.stat[ST_LV];
  assign oc_hs_off = oc_all_off | st.stat[ST_HV] | (st.stat[ST_OC] & ~st.ctrl[CTRL_ACT0]) |
    (st.stat[ST_OC+1] & ~st.ctrl[CTRL_ACT1]);
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      // Low-side PWM index 2g+1, high-side 2g; flag clear resumes PWM
      assign GATE_OUT[2*g] = PWM_IN[2*g] & ~st.stat[ST_HS+g] & ~oc_hs_off;
      assign GATE_OUT[2*g+1] = oc_all_off ? 1'b0 : (oc_hs_off ? 1'b1 : (PWM_IN[2*g+1] & ~st.stat[ST_LS+g]));
    end
  endgenerate

  // Level requests, masked in stop mode
  logic [ST_BITS-1:0] pend;
  assign pend = st.stat & st.irq_en;
  assign IRQ0_OUT = ~stop_mode & (|pend[ST_LV-1:0]);
  assign IRQ1_OUT = ~stop_mode & (|pend[ST_BITS-1:ST_LV]);

  // Checks
  property p_irq0;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (|(st.stat[5:0] & st.irq_en[5:0]) && !stop_mode) |-> IRQ0_OUT;
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 missing");

  property p_irq1;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (|(st.stat[9:6] & st.irq_en[9:6]) && !stop_mode) |-> IRQ1_OUT;
  endproperty
  a_irq1: assert property (p_irq1) else $error("irq1 missing");

  property p_stop;
    @(posedge CLK_IN) disable iff (SRST_IN) stop_mode |-> !IRQ0_OUT && !IRQ1_OUT;
  endproperty
  a_stop: assert property (p_stop) else $error("irq in stop mode");

  property p_sticky;
    @(posedge CLK_IN) disable iff (SRST_IN)
      (st.stat[0] && !(WR_IN && ADDR_IN == ADDR_IRQ_CLR && WDATA_IN[0])) |=> st.stat[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  sequence s_clear_hs0;
    WR_IN && ADDR_IN == ADDR_IRQ_CLR && WDATA_IN[0] && !hs_desat[0];
  endsequence
  property p_clear;
    @(posedge CLK_IN) disable iff (SRST_IN) s_clear_hs0 |=> !st.stat[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_boost;
    @(posedge CLK_IN) disable iff (SRST_IN) (!st.ctrl[CTRL_BOOST_EN] || !below_ref) |-> !BOOST_SWITCH_OUT;
  endproperty
  a_boost: assert property (p_boost) else $error("boost not gated");

  property p_dac;
    @(posedge CLK_IN) disable iff (SRST_IN) OC_DAC0_OUT[5:4] == 2'h3 && OC_DAC1_OUT[5:4] == 2'h3;
  endproperty
  a_dac: assert property (p_dac) else $error("dac prefix wrong");

  property p_oc_gate;
    @(posedge CLK_IN) disable iff (SRST_IN) oc_raw[0] && !(OC_CMP_EN_OUT[0] && SENSE_AMP_EN_OUT[0]) && !st.stat[8]
      && !(WR_IN && ADDR_IN == ADDR_IRQ_EN) |=> !st.stat[8];
  endproperty
  a_oc_gate: assert property (p_oc_gate) else $error("disabled comparator flagged");

  property p_slew;
    @(posedge CLK_IN) disable iff (SRST_IN) SLEW_REF_UA_OUT == 7'(10 + 10 * HIGH_SIDE_SLEW_SEL_OUT);
  endproperty
  a_slew: assert property (p_slew) else $error("slew current wrong");

  property p_div;
    @(posedge CLK_IN) disable iff (SRST_IN) boost_tick |=> st.div_cnt == $past(st.boost_div);
  endproperty
  a_div: assert property (p_div) else $error("divider reload wrong");

  // Register, gating and flag-keeping checks
  property p_irq0_idle;
    @(posedge CLK_IN) disable iff (SRST_IN)
      !(|pend[ST_LV-1:0]) |-> !IRQ0_OUT;
  endproperty
  a_irq0_idle: assert property (p_irq0_idle) else $error("irq0 without pending flag");

  property p_irq1_idle;
    @(posedge CLK_IN) disable iff (SRST_IN)
      !(|pend[ST_BITS-1:ST_LV]) |-> !IRQ1_OUT;
  endproperty
  a_irq1_idle: assert property (p_irq1_idle) else $error("irq1 without pending flag");

  sequence s_set_and_clear;
    events[ST_LV] && clr[ST_LV];
  endsequence
  property p_set_wins;
    @(posedge CLK_IN) disable iff (SRST_IN)
      s_set_and_clear |=> st.stat[ST_LV];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

  property p_oc_set;
    @(posedge CLK_IN) disable iff (SRST_IN)
      oc_live[1] |=> st.stat[ST_OC+1];
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("enabled comparator not flagged");

  property p_dcl;
    @(posedge CLK_IN) disable iff (SRST_IN)
      WR_IN && ADDR_IN == ADDR_CTRL |=> DC_LINK_MUX_EN_OUT == $past(WDATA_IN[CTRL_DCL_EN]);
  endproperty
  a_dcl: assert property (p_dcl) else $error("dc link routing wrong");

  property p_offset_wr;
    @(posedge CLK_IN) disable iff (SRST_IN)
      WR_IN && ADDR_IN == ADDR_SENSE |=> SENSE_OFFSET_SEL_OUT == $past(WDATA_IN[2:0]);
  endproperty
  a_offset_wr: assert property (p_offset_wr) else $error("offset select wrong");

  property p_limit_wr;
    @(posedge CLK_IN) disable iff (SRST_IN)
      WR_IN && ADDR_IN == ADDR_BOOST |=> BOOST_CURRENT_LIMIT_OUT == $past(WDATA_IN[DIV_WIDTH+3:DIV_WIDTH]);
  endproperty
  a_limit_wr: assert property (p_limit_wr) else $error("coil limit wrong");

  property p_hs_gate;
    @(posedge CLK_IN) disable iff (SRST_IN)
      st.stat[ST_HS] |-> !GATE_OUT[0];
  endproperty
  a_hs_gate: assert property (p_hs_gate) else $error("flagged high side still driven");

  property p_ls_gate;
    @(posedge CLK_IN) disable iff (SRST_IN)
      st.stat[ST_LS] && !oc_hs_off |-> !GATE_OUT[1];
  endproperty
  a_ls_gate: assert property (p_ls_gate) else $error("flagged low side still driven");

  sequence s_boost_on;
    st.ctrl[CTRL_BOOST_EN] && below_ref && st.boost_clk;
  endsequence
  property p_boost_run;
    @(posedge CLK_IN) disable iff (SRST_IN)
      s_boost_on |-> BOOST_SWITCH_OUT;
  endproperty
  a_boost_run: assert property (p_boost_run) else $error("boost clock blocked");

  property p_tick_pulse;
    @(posedge CLK_IN) disable iff (SRST_IN)
      boost_tick && st.boost_div != '0 |=> !boost_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("divider tick too long");

  property p_stop_keep;
    @(posedge CLK_IN) disable iff (SRST_IN)
      stop_mode != $past(stop_mode) && clr == '0 |=> (st.stat & $past(st.stat)) == $past(st.stat);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("flag lost on mode change");

  property p_slew_range;
    @(posedge CLK_IN) disable iff (SRST_IN)
      SLEW_REF_UA_OUT >= 7'h0a && SLEW_REF_UA_OUT <= 7'h50;
  endproperty
  a_slew_range: assert property (p_slew_range) else $error("slew current out of range");
endmodule

// ==== testbench/gdm_bridge.sv ====
`timescale 1ns/100ps
// Bridge model: a shorted FET only shows desaturation while its gate is on,
// so the fault drops by itself once the pre-driver turns that gate off
module gdm_bridge (
  input wire logic [5:0] gate_in,
  input wire logic [5:0] short_in,
  output logic [2:0] hs_desat_out,
  output logic [2:0] ls_desat_out
);
  // Even gates are high side, odd gates low side of phase g
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      hs_desat_out[g] = gate_in[2*g] & short_in[2*g];
      ls_desat_out[g] = gate_in[2*g+1] & short_in[2*g+1];
    end
  end
endmodule

// ==== testbench/gate_drive_monitor_control_bench.sv ====
`timescale 1ns/100ps
module gate_drive_monitor_control_bench;
  import gdm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] shrt = 6'h00;
  logic [5:0] pwm = 6'h00;
  logic [1:0] oc = 2'h0;
  logic lv = 1'b0;
  logic hv = 1'b0;
  logic below = 1'b0;
  logic stop = 1'b0;
  logic [31:0] rdata;
  logic [2:0] hs, ls, sel, slew_sel;
  logic [1:0] amp, cmp;
  logic [5:0] dac0, dac1, gate;
  logic dcl, bsw, irq0, irq1;
  logic [3:0] blim;
  logic [6:0] slew_ua;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int st = 0;
  int en = 0;
  int n, g;
  logic [31:0] v;

  // Free running bench clock
  always #10 clk = ~clk;

  gdm_core dut_u (.CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .HS_DESAT_IN(hs), .LS_DESAT_IN(ls),
    .LOW_VOLTAGE_IN(lv), .HIGH_VOLTAGE_IN(hv), .OC_CMP_IN(oc), .SUPPLY_BELOW_REF_IN(below),
    .STOP_MODE_IN(stop), .PWM_IN(pwm), .SENSE_OFFSET_SEL_OUT(sel), .SENSE_AMP_EN_OUT(amp),
    .OC_CMP_EN_OUT(cmp), .OC_DAC0_OUT(dac0), .OC_DAC1_OUT(dac1), .DC_LINK_MUX_EN_OUT(dcl),
    .BOOST_CURRENT_LIMIT_OUT(blim), .BOOST_SWITCH_OUT(bsw), .HIGH_SIDE_SLEW_SEL_OUT(slew_sel),
    .SLEW_REF_UA_OUT(slew_ua), .GATE_OUT(gate), .IRQ0_OUT(irq0), .IRQ1_OUT(irq1));

  gdm_bridge bridge_u (.gate_in(gate), .short_in(shrt), .hs_desat_out(hs), .ls_desat_out(ls));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(nm, rdata, e);
  endtask

  // Inputs pass two sync flops plus the flag register
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Model status against the device and both request lines
  task automatic cmp_all;
    rd_chk("status", ADDR_IRQ_STAT, st);
    check("irq0", irq0, 32'((st & en & 'h3f) != 0 && !stop));
    check("irq1", irq1, 32'((st & en & 'h3c0) != 0 && !stop));
  endtask

  // Count changes of the boost switch over 60 cycles
  task automatic toggles(input int exp);
    settle();
    n = 0;
    v[0] = bsw;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (bsw !== v[0]) n++;
      v[0] = bsw;
    end
    check("boost toggles", n, exp);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far above the roughly 810 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    v = $urandom(32'h5753ae58);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd_chk("ctrl", ADDR_CTRL, 32'h0);
    rd_chk("boost", ADDR_BOOST, 32'h1);
    rd_chk("unmapped", 6'h24, 32'h0);
    rd_chk("clear reads 0", ADDR_IRQ_CLR, 32'h0);
    check("dac reset", dac0, 32'h30);
    // Random analog settings, every slew code
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr_reg(ADDR_SENSE, v[2:0]);
      wr_reg(ADDR_OCTHR, v[10:3]);
      wr_reg(ADDR_BOOST, {v[14:11], 8'h02});
      wr_reg(ADDR_SLEW, i);
      check("offset", sel, v[2:0]);
      check("dac0", dac0, {2'b11, v[6:3]});
      check("dac1", dac1, {2'b11, v[10:7]});
      check("limit", blim, v[14:11]);
      check("slew", slew_ua, 10 + 10 * i);
      check("slew sel", slew_sel, i);
    end
    wr_reg(ADDR_CTRL, 32'h40);
    check("dc link mux", dcl, 32'h1);
    @(posedge clk) below <= 1'b1;
    toggles(0);
    wr_reg(ADDR_CTRL, 32'hc0);
    check("dc link mux", dcl, 32'h1);
    toggles(20);
    @(posedge clk) below <= 1'b0;
    toggles(0);
    check("boost idle", bsw, 32'h0);
    // Comparators without amplifiers must stay silent; actions kept equal
    wr_reg(ADDR_CTRL, 32'h03);
    check("dc link off", dcl, 32'h0);
    check("amp off", amp, 32'h0);
    wr_reg(ADDR_IRQ_EN, 32'h3ff);
    en = 'h3ff;
    @(posedge clk) oc <= 2'h3;
    settle();
    cmp_all();
    @(posedge clk) oc <= 2'h0;
    wr_reg(ADDR_CTRL, 32'h0f);
    check("cmp en", cmp, 32'h3);
    check("amp en", amp, 32'h3);
    // One event per status bit
    for (int k = 0; k < 10; k++) begin
      g = k < 3 ? 2 * k : 2 * (k - 3) + 1;
      @(posedge clk);
      pwm <= 6'h3f;
      shrt <= k < 6 ? 6'(1 << g) : 6'h00;
      lv <= k == 6;
      hv <= k == 7;
      oc <= {k == 9, k == 8};
      settle();
      if (k < 6)
        check("gates", gate, 6'h3f & ~6'(1 << g));
      @(posedge clk);
      shrt <= 6'h00;
      lv <= 1'b0;
      hv <= 1'b0;
      oc <= 2'h0;
      settle();
      st = 1 << k;
      cmp_all();
      @(posedge clk) stop <= 1'b1;
      settle();
      cmp_all();
      @(posedge clk) stop <= 1'b0;
      settle();
      cmp_all();
      en = 0;
      wr_reg(ADDR_IRQ_EN, 32'h0);
      cmp_all();
      en = 'h3ff;
      wr_reg(ADDR_IRQ_EN, 32'h3ff);
      wr_reg(ADDR_IRQ_CLR, st);
      st = 0;
      @(posedge clk) pwm <= 6'($urandom);
      settle();
      cmp_all();
      check("gates follow", gate, pwm);
    end
    print_verdict();
  end
endmodule
